//--- rtl/pcm_pkg.sv
// Purpose: shared constants and types for the configuration cycle master
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   command codes follow the PCI configuration read/write encodings

// ============================================================
// package
package pcm_pkg;

  // host side address width (byte address inside the config window)
  localparam int HOST_AW = 24;

  // PCI bus commands driven on the command/byte-enable lines
  localparam logic [3:0] CMD_CFG_READ = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;

  // mode select and field positions of the host address
  localparam logic [1:0] DECODE_SEL = 2'h3;
  localparam int SEL_HI = 23;
  localparam int SEL_LO = 22;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 11;
  localparam int DIRECT_HI = 23;
  localparam int DEC_COPY_HI = 10;
  localparam int DWORD_LO = 2;
  localparam int DEC_FIELD_W = 21;
  localparam logic [4:0] DECODE_MAX = 5'h14;

  // low address bits for the two configuration types
  localparam logic [1:0] TYPE0_LOW = 2'h0;
  localparam logic [1:0] TYPE1_LOW = 2'h1;

  // cycles after the address phase before master abort is declared
  localparam logic [2:0] MASTER_ABORT_CYCLES = 3'h5;

  // read data returned when the cycle is aborted
  localparam logic [31:0] ABORT_READ_DATA = 32'hFFFFFFFF;

  // status word layout and reset value
  localparam int STAT_MASTER_ABORT = 29;
  localparam int STAT_TARGET_ABORT = 28;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;

  // bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_TURN = 3'b100
  } pcm_state_type;

  // how the single data phase ended
  typedef enum logic [1:0] {
    RES_OK = 2'b00,
    RES_RETRY = 2'b01,
    RES_MABORT = 2'b10,
    RES_TABORT = 2'b11
  } pcm_result_type;

endpackage

//--- rtl/pcm_addr_if.sv
// Purpose: carries the latched host address to the address generator
// Assumes: driven from flip-flops held for a whole transaction
// Notes:   requester modport drives, generator modport answers

`timescale 1ns/1ps
`default_nettype none

// ============================================================
// interface
interface pcm_addr_if
  import pcm_pkg::*;
();
  logic [HOST_AW-1:0] host_addr;
  logic type1;
  logic [31:0] pci_addr;
  logic decoded;

  modport requester (output host_addr, output type1,
                     input pci_addr, input decoded);
  modport generator (input host_addr, input type1,
                     output pci_addr, output decoded);
endinterface

`default_nettype wire

//--- rtl/pcm_addr_gen.sv
// Purpose: forms the PCI configuration address from the host address
// Assumes: inputs stable while the transaction runs
// Notes:   purely combinational; clock and reset serve the checks only

`timescale 1ns/1ps
`default_nettype none

// ============================================================
// address generator
module pcm_addr_gen
  import pcm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // address carrier
  pcm_addr_if.generator aif
);

  // one-hot decode of the device select code
  function automatic logic [DEC_FIELD_W-1:0] dev_decode(
    input logic [4:0] code
  );
    logic [DEC_FIELD_W-1:0] v;
    v = '0;
    if (code != 5'h00 && code <= DECODE_MAX)
    begin
      v[code] = 1'b1;
    end
    return v;
  endfunction

  logic dec_mode;
  logic [4:0] code;

  // mode select and address assembly
  always_comb
  begin
    code = aif.host_addr[CODE_HI:CODE_LO];
    dec_mode = (aif.host_addr[SEL_HI:SEL_LO] == DECODE_SEL) && !aif.type1;
    if (dec_mode)
    begin
      aif.pci_addr = {dev_decode(code),                      // see R06, R07
                      aif.host_addr[DEC_COPY_HI:DWORD_LO],   // see R08
                      TYPE0_LOW};                            // see R08
    end
    else
    begin
      aif.pci_addr = {8'h00,                                 // see R03
                      aif.host_addr[DIRECT_HI:DWORD_LO],     // see R04
                      aif.type1 ? TYPE1_LOW : TYPE0_LOW};    // see R05
    end
    aif.decoded = dec_mode;
  end

  a_direct_upper: assert property (@(posedge clock) // see R03
    disable iff (srst) !aif.decoded |-> aif.pci_addr[31:24] == 8'h00)
    else $error("direct mode upper bits not zero");

  a_direct_copy: assert property (@(posedge clock) // see R04
    disable iff (srst) !aif.decoded |->
      aif.pci_addr[23:2] == aif.host_addr[DIRECT_HI:DWORD_LO])
    else $error("direct mode address not copied");

  a_direct_type: assert property (@(posedge clock) // see R05
    disable iff (srst) !aif.decoded |->
      aif.pci_addr[1:0] == (aif.type1 ? TYPE1_LOW : TYPE0_LOW))
    else $error("direct mode type bits wrong");

  a_decode_select: assert property (@(posedge clock) // see R07
    disable iff (srst)
    aif.decoded |-> (aif.host_addr[15:11] inside {[5'h01:5'h14]}
      ? aif.pci_addr[11 + aif.host_addr[15:11]] &&
        $onehot(aif.pci_addr[31:11])
      : aif.pci_addr[31:11] == '0))
    else $error("device select decode wrong");

  a_decode_low: assert property (@(posedge clock) disable iff (srst) // see R08
    aif.decoded |-> aif.pci_addr[10:0] ==
      {aif.host_addr[DEC_COPY_HI:DWORD_LO], TYPE0_LOW})
    else $error("decoded mode low bits wrong");

endmodule

`default_nettype wire

//--- rtl/pcm_status.sv
// Purpose: sticky abort flags and the host interrupt they raise
// Assumes: set and clear are one-cycle pulses
// Notes:   a set arriving with its clear wins

`timescale 1ns/1ps
`default_nettype none

// ============================================================
// abort status
module pcm_status
  import pcm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // events and software control
  input wire logic set_master_abort,
  input wire logic set_target_abort,
  input wire logic clr_master_abort,
  input wire logic clr_target_abort,
  input wire logic abort_irq_enable,
  // results
  output logic [31:0] status,
  output logic host_irq
);

  logic ma_q;
  logic ta_q;

  // received master abort flag
  always_ff @(posedge clock)
  begin
    if (srst)
      ma_q <= STATUS_RESET[STAT_MASTER_ABORT];
    else if (set_master_abort)
      ma_q <= 1'b1;  // see R13, R15
    else if (clr_master_abort)
      ma_q <= 1'b0;
  end

  // received target abort flag
  always_ff @(posedge clock)
  begin
    if (srst)
      ta_q <= STATUS_RESET[STAT_TARGET_ABORT];
    else if (set_target_abort)
      ta_q <= 1'b1;  // see R14, R16
    else if (clr_target_abort)
      ta_q <= 1'b0;
  end

  // status word and gated interrupt
  always_comb
  begin
    status = STATUS_RESET;
    status[STAT_MASTER_ABORT] = ma_q;
    status[STAT_TARGET_ABORT] = ta_q;
  end
  assign host_irq = abort_irq_enable && (ma_q || ta_q); // see R13, R14

  a_set_wins: assert property (@(posedge clock) disable iff (srst) // see R13
    set_master_abort && clr_master_abort |=> ma_q)
    else $error("master abort set lost to clear");

endmodule

`default_nettype wire

//--- rtl/pcm_top.sv
// Purpose: turns host configuration-space accesses into PCI config cycles
// Assumes: PCI pins synchronous to clock; host holds request until ready
// Notes:   single data phase per cycle; retried cycles reuse latched state
//
// What this block does
// R01: A host write inside the config window starts one PCI config write.
// R02: A host read inside the config window starts one PCI config read.
// R03: Unless select bits are 11 on a type 0 access, upper address is zero.
// R04: In direct mode host bits 23 to 2 pass unchanged to the PCI address.
// R05: In direct mode the low two bits are 00 for type 0 and 01 for type 1.
// R06: Select bits 11 on a type 0 access decode bits 15:11 onto bits 31:11.
// R07: Codes 1 to 20 give one bit rising per code, others give all zeros.
// R08: In decoded mode bits 10 to 2 are copied and the low two bits are 00.
// R09: Host software forms a meaningful address with one device select set.
// R10: Write byte enables come from the host byte-lane size, one Dword only.
// R11: A retried config write is reissued at the earliest opportunity.
// R12: A retried config read is reissued at the earliest opportunity.
// R13: A write master abort drops data, sets status bit 29, may interrupt.
// R14: A write target abort drops data, sets status bit 28, may interrupt.
// R15: A read master abort returns all ones and sets status bit 29.
// R16: A read target abort returns all ones and sets status bit 28.
// R17: A reissued cycle keeps the same address, byte enables and data.

`timescale 1ns/1ps
`default_nettype none

// ============================================================
// top
module pcm_top
  import pcm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // host request
  input wire logic host_req,
  input wire logic host_write,
  input wire logic host_type1,
  input wire logic [HOST_AW-1:0] host_addr,
  input wire logic [3:0] host_byte_lane_size,
  input wire logic [31:0] host_wdata,
  output logic host_ready,
  // host answer
  output logic host_done,
  output logic [31:0] host_rdata,
  // status and interrupt
  input wire logic clr_master_abort,
  input wire logic clr_target_abort,
  input wire logic abort_irq_enable,
  output logic [31:0] status,
  output logic host_irq,
  // PCI arbitration
  output logic req_l,
  input wire logic gnt_l,
  // PCI control pins
  input wire logic frame_l_in,
  output logic frame_l_out,
  output logic frame_l_oe,
  input wire logic irdy_l_in,
  output logic irdy_l_out,
  output logic irdy_l_oe,
  input wire logic devsel_l_in,
  input wire logic trdy_l_in,
  input wire logic stop_l_in,
  // PCI address/data and command/byte enables
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic [3:0] cbe_l_out,
  output logic cbe_l_oe
);

  pcm_state_type state_q;
  pcm_result_type result_q;
  logic write_q;
  logic type1_q;
  logic [HOST_AW-1:0] addr_q;
  logic [3:0] be_l_q;
  logic [31:0] wdata_q;
  logic [2:0] wait_q;
  logic devsel_seen_q;
  logic done_q;
  logic [31:0] rdata_q;

  logic bus_idle;
  logic phase_ok;
  logic phase_retry;
  logic phase_tabort;
  logic phase_mabort;
  logic phase_end;

  pcm_addr_if aif ();

  // ============================================================
  // address generation from the latched request
  assign aif.host_addr = addr_q; // see R17
  assign aif.type1 = type1_q;

  pcm_addr_gen u_addr_gen (
    .clock (clock),
    .srst (srst),
    .aif (aif.generator)
  );

  // ============================================================
  // data phase outcome decode
  assign bus_idle = frame_l_in && irdy_l_in;
  assign phase_ok = !devsel_l_in && !trdy_l_in;
  assign phase_retry = !devsel_l_in && trdy_l_in && !stop_l_in;
  assign phase_tabort = devsel_l_in && devsel_seen_q && !stop_l_in;
  assign phase_mabort = devsel_l_in && !devsel_seen_q &&
                        (wait_q >= MASTER_ABORT_CYCLES);
  assign phase_end = (state_q == ST_DATA) &&
                     (phase_ok || phase_retry || phase_tabort ||
                      phase_mabort);

  // ============================================================
  // sequencer
  always_ff @(posedge clock)
  begin
    if (srst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (host_req)
            state_q <= ST_REQ; // see R01, R02
        ST_REQ:
          if (!gnt_l && bus_idle)
            state_q <= ST_ADDR;
        ST_ADDR:
          state_q <= ST_DATA;
        ST_DATA:
          if (phase_end)
            state_q <= ST_TURN;
        ST_TURN:
          if (result_q == RES_RETRY)
            state_q <= ST_REQ; // see R11, R12
          else
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // request capture, held unchanged across retries
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      write_q <= 1'b0;
      type1_q <= 1'b0;
      addr_q <= '0;
      be_l_q <= 4'hF;
      wdata_q <= 32'h00000000;
    end
    else if (state_q == ST_IDLE && host_req)
    begin
      write_q <= host_write;
      type1_q <= host_type1;
      addr_q <= host_addr;
      be_l_q <= ~host_byte_lane_size; // see R10
      wdata_q <= host_wdata;          // see R17
    end
  end

  // devsel watch and master abort timer
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wait_q <= 3'h0;
      devsel_seen_q <= 1'b0;
    end
    else if (state_q == ST_ADDR)
    begin
      wait_q <= 3'h1;
      devsel_seen_q <= 1'b0;
    end
    else if (state_q == ST_DATA)
    begin
      if (wait_q < MASTER_ABORT_CYCLES)
        wait_q <= wait_q + 3'h1;
      if (!devsel_l_in)
        devsel_seen_q <= 1'b1;
    end
  end

  // outcome of the data phase
  always_ff @(posedge clock)
  begin
    if (srst)
      result_q <= RES_OK;
    else if (phase_end)
    begin
      if (phase_ok)
        result_q <= RES_OK;
      else if (phase_retry)
        result_q <= RES_RETRY;
      else if (phase_tabort)
        result_q <= RES_TABORT;
      else
        result_q <= RES_MABORT;
    end
  end

  // host answer: read data and completion pulse
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      done_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      done_q <= phase_end && !phase_ok && phase_retry ? 1'b0 : phase_end;
      if (phase_end && !write_q)
      begin
        if (phase_ok)
          rdata_q <= ad_in;
        else if (!phase_retry)
          rdata_q <= ABORT_READ_DATA; // see R15, R16
      end
    end
  end
  assign host_done = done_q;
  assign host_rdata = rdata_q;
  assign host_ready = (state_q == ST_IDLE);

  // ============================================================
  // abort status; write data is simply dropped on abort
  pcm_status u_status (
    .clock (clock),
    .srst (srst),
    .set_master_abort (phase_end && !phase_ok && !phase_retry &&
                       !phase_tabort), // see R13, R15
    .set_target_abort (phase_end && !phase_ok && !phase_retry &&
                       phase_tabort),  // see R14, R16
    .clr_master_abort (clr_master_abort),
    .clr_target_abort (clr_target_abort),
    .abort_irq_enable (abort_irq_enable),
    .status (status),
    .host_irq (host_irq)
  );

  // ============================================================
  // pin drive: one address phase, then exactly one data phase
  always_comb
  begin
    req_l = !(state_q == ST_REQ);
    frame_l_oe = (state_q == ST_ADDR) || (state_q == ST_DATA);
    frame_l_out = !(state_q == ST_ADDR); // see R02, R10
    irdy_l_oe = (state_q == ST_DATA) || (state_q == ST_TURN);
    irdy_l_out = !(state_q == ST_DATA);
    cbe_l_oe = (state_q == ST_ADDR) || (state_q == ST_DATA);
    ad_oe = (state_q == ST_ADDR) || (state_q == ST_DATA && write_q);
    if (state_q == ST_ADDR)
    begin
      ad_out = aif.pci_addr;
      cbe_l_out = write_q ? CMD_CFG_WRITE : CMD_CFG_READ; // see R01, R02
    end
    else
    begin
      ad_out = wdata_q;
      cbe_l_out = be_l_q; // see R10
    end
  end

  // ============================================================
  // checks
  a_retry_reissue: assert property (@(posedge clock) // see R11, R12
    disable iff (srst)
    phase_end && phase_retry && !phase_ok |=> ##1 state_q == ST_REQ)
    else $error("retried cycle not reissued");

  a_retry_same: assert property (@(posedge clock) // see R17
    disable iff (srst) state_q == ST_TURN && result_q == RES_RETRY |=>
      $stable(addr_q) && $stable(wdata_q) && $stable(be_l_q) &&
      $stable(write_q) && $stable(type1_q))
    else $error("retry changed request");

  a_abort_ones: assert property (@(posedge clock) // see R15, R16
    disable iff (srst)
    phase_end && !write_q && (phase_mabort || phase_tabort) &&
      !phase_ok && !phase_retry |=> host_rdata == ABORT_READ_DATA)
    else $error("aborted read not all ones");

  a_mabort_flag: assert property (@(posedge clock) // see R13, R15
    disable iff (srst)
    phase_end && phase_mabort && !phase_ok && !phase_retry &&
      !phase_tabort |=> status[STAT_MASTER_ABORT])
    else $error("master abort flag not set");

  a_addr_phase: assert property (@(posedge clock) // see R01
    disable iff (srst) state_q == ST_ADDR |-> ad_oe && !frame_l_out &&
      ad_out == aif.pci_addr)
    else $error("address phase drive wrong");

  a_single_dword: assert property (@(posedge clock) // see R02, R10
    disable iff (srst) state_q == ST_DATA |-> frame_l_out && !irdy_l_out)
    else $error("more than one data phase");

  a_done_once: assert property (@(posedge clock) // see R01
    disable iff (srst) host_done |=> !host_done && host_ready)
    else $error("completion pulse malformed");

endmodule

`default_nettype wire

//--- tb/pcm_target.sv
// Purpose: behavioural PCI target answering config cycles of the master
// Assumes: one data phase per cycle; control lines pulled up when released
// Notes:   mode 0 ok, 1 no claim (master abort), 2 target abort

`timescale 1ns/1ps
`default_nettype none

// ============================================================
// target model
module pcm_target
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // scenario control
  input wire logic [1:0] mode,
  input wire logic [1:0] retry_n,
  input wire logic [31:0] read_data,
  // master side pins
  input wire logic frame_l_out,
  input wire logic frame_l_oe,
  input wire logic irdy_l_out,
  input wire logic irdy_l_oe,
  input wire logic [31:0] ad_out,
  input wire logic [3:0] cbe_l_out,
  input wire logic ad_oe,
  input wire logic cbe_l_oe,
  // target answers
  output logic devsel_l,
  output logic trdy_l,
  output logic stop_l,
  output logic [31:0] ad_in,
  // observations
  output logic [31:0] addr_seen,
  output logic [3:0] cmd_seen,
  output logic [3:0] be_seen,
  output logic [31:0] wdata_seen,
  output logic [7:0] addr_count
);
  logic ta_step;
  logic [1:0] retry_cnt;

  // answer each address phase, then release the lines after the data phase
  always @(posedge clock)
  begin
    if (srst)
    begin
      {devsel_l, trdy_l, stop_l} <= 3'h7;
      ad_in <= 32'h00000000;
      addr_seen <= 32'h00000000;
      addr_count <= 8'h00;
      ta_step <= 1'b0;
      retry_cnt <= 2'h0;
    end
    else if (frame_l_oe && !frame_l_out)
    begin
      // undriven lines show the inverse, so a missing enable is caught
      addr_seen <= ad_oe ? ad_out : ~ad_out;
      cmd_seen <= cbe_l_oe ? cbe_l_out : ~cbe_l_out;
      addr_count <= addr_count + 8'h01;
      ta_step <= 1'b0;
      if (retry_cnt < retry_n)
      begin
        retry_cnt <= retry_cnt + 2'h1;
        {devsel_l, trdy_l, stop_l} <= 3'h2;
      end
      else
      begin
        retry_cnt <= 2'h0;
        if (mode == 2'h0)
          {devsel_l, trdy_l, stop_l} <= 3'h1;
        else if (mode == 2'h2)
          {devsel_l, trdy_l, stop_l} <= 3'h3;
        ad_in <= read_data;
        ta_step <= (mode == 2'h2);
      end
    end
    else if (irdy_l_oe && !irdy_l_out)
    begin
      if (ta_step)
      begin
        // claimed first, now drop devsel with stop low
        {devsel_l, stop_l} <= 2'h2;
        ta_step <= 1'b0;
      end
      else if (!devsel_l || !stop_l)
      begin
        be_seen <= cbe_l_oe ? cbe_l_out : ~cbe_l_out;
        wdata_seen <= ad_oe ? ad_out : ~ad_out;
        {devsel_l, trdy_l, stop_l} <= 3'h7;
        ad_in <= ~ad_in; // released lines must not keep old data
      end
    end
  end
endmodule

`default_nettype wire

//--- tb/pcm_top_test.sv
// Purpose: self-checking bench for the configuration cycle master
// Assumes: target model answers on the PCI side, grant always given
// Notes:   inputs change 1 ns after the rising clock edge

`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench top
module pcm_top_test
  import pcm_pkg::*;
();
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic host_req = 1'b0, host_write = 1'b0, host_type1 = 1'b0;
  logic [23:0] host_addr = 24'h000000;
  logic [3:0] host_byte_lane_size = 4'hF;
  logic [31:0] host_wdata = 32'h00000000, read_data = 32'h00000000;
  logic clr_master_abort = 1'b0, clr_target_abort = 1'b0;
  logic abort_irq_enable = 1'b0, gnt_l = 1'b0;
  logic [1:0] mode = 2'h0, retry_n = 2'h0;
  logic host_ready, host_done, host_irq, req_l;
  logic frame_l_out, frame_l_oe, irdy_l_out, irdy_l_oe, ad_oe, cbe_l_oe;
  logic devsel_l, trdy_l, stop_l;
  logic [31:0] host_rdata, status, ad_in, ad_out, addr_seen, wdata_seen;
  logic [3:0] cbe_l_out, cmd_seen, be_seen;
  logic [7:0] addr_count;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // 100 ns clock
  always #50 clock = ~clock;

  pcm_top dut (.clock(clock), .srst(srst), .host_req(host_req),
    .host_write(host_write), .host_type1(host_type1),
    .host_addr(host_addr), .host_byte_lane_size(host_byte_lane_size),
    .host_wdata(host_wdata), .host_ready(host_ready),
    .host_done(host_done), .host_rdata(host_rdata),
    .clr_master_abort(clr_master_abort),
    .clr_target_abort(clr_target_abort),
    .abort_irq_enable(abort_irq_enable), .status(status),
    .host_irq(host_irq), .req_l(req_l), .gnt_l(gnt_l),
    .frame_l_in(frame_l_oe ? frame_l_out : 1'b1),
    .frame_l_out(frame_l_out), .frame_l_oe(frame_l_oe),
    .irdy_l_in(irdy_l_oe ? irdy_l_out : 1'b1),
    .irdy_l_out(irdy_l_out), .irdy_l_oe(irdy_l_oe),
    .devsel_l_in(devsel_l), .trdy_l_in(trdy_l), .stop_l_in(stop_l),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .cbe_l_out(cbe_l_out), .cbe_l_oe(cbe_l_oe));

  pcm_target target (.clock(clock), .srst(srst), .mode(mode),
    .retry_n(retry_n), .read_data(read_data),
    .frame_l_out(frame_l_out), .frame_l_oe(frame_l_oe),
    .irdy_l_out(irdy_l_out), .irdy_l_oe(irdy_l_oe), .ad_out(ad_out),
    .ad_oe(ad_oe), .cbe_l_oe(cbe_l_oe),
    .cbe_l_out(cbe_l_out), .devsel_l(devsel_l), .trdy_l(trdy_l),
    .stop_l(stop_l), .ad_in(ad_in), .addr_seen(addr_seen),
    .cmd_seen(cmd_seen), .be_seen(be_seen), .wdata_seen(wdata_seen),
    .addr_count(addr_count));

  // verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected PCI address of a config access
  function automatic logic [31:0] exp_addr(input logic t1,
                                           input logic [23:0] a);
    logic [31:0] r;
    r = {8'h00, a[23:2], t1 ? TYPE1_LOW : TYPE0_LOW};
    if (a[23:22] == 2'h3 && !t1)
    begin
      r = {21'h0, a[10:2], 2'h0};
      if (a[15:11] != 5'h00 && a[15:11] <= 5'h14)
        r[11 + a[15:11]] = 1'b1;
    end
    return r;
  endfunction

  // one host access, held until taken, then wait for completion
  task automatic host_op(input logic wr, input logic t1,
                         input logic [23:0] a, input logic [3:0] be,
                         input logic [31:0] wd);
    int n;
    {host_write, host_type1, host_addr} = {wr, t1, a};
    {host_byte_lane_size, host_wdata, host_req} = {be, wd, 1'b1};
    n = 0;
    while (host_ready !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    #1 host_req = 1'b0;
    n = 0;
    while (host_done !== 1'b1 && n < 200)
    begin
      @(posedge clock);
      #1 n++;
    end
    check({31'h0, host_done}, 32'h1);
    check({31'h0, req_l}, 32'h1);
  endtask

  // direct mapping, write then read, both config types
  task automatic t_direct();
    logic [23:0] a [3] = '{24'h800A44, 24'hC12349, 24'h7FFFFC};
    logic [3:0] be [3] = '{4'h5, 4'hF, 4'h1};
    logic [7:0] c0;
    for (int i = 0; i < 3; i++)
    begin
      c0 = addr_count;
      host_op(1'b1, i[0], a[i], be[i], 32'hC0DE0000 + i);
      check(addr_seen, exp_addr(i[0], a[i]));
      check({28'h0, cmd_seen}, {28'h0, CMD_CFG_WRITE});
      check({28'h0, be_seen}, {28'h0, ~be[i]});
      check(wdata_seen, 32'hC0DE0000 + i);
      read_data = 32'h12345670 + i;
      host_op(1'b0, i[0], a[i], be[i], 32'h0);
      check({28'h0, cmd_seen}, {28'h0, CMD_CFG_READ});
      check(host_rdata, 32'h12345670 + i);
      check({24'h0, addr_count}, {24'h0, c0 + 8'h02});
    end
  endtask

  // one-hot decode of every code, at most one device select per address
  task automatic t_decode();
    logic [23:0] a;
    for (int c = 0; c < 32; c++)
    begin
      a = {2'h3, 6'h2A, c[4:0], 9'h0A5, 2'h2};
      host_op(c[0], 1'b0, a, 4'hF, 32'h5A5A0000 + c);
      check(addr_seen, exp_addr(1'b0, a));
    end
  endtask

  // retried write and read come back identical
  task automatic t_retry();
    logic [7:0] c0;
    c0 = addr_count;
    retry_n = 2'h2;
    host_op(1'b1, 1'b0, 24'h012344, 4'h6, 32'hFACE0001);
    check({24'h0, addr_count}, {24'h0, c0 + 8'h03});
    check(addr_seen, 32'h00012344);
    check({28'h0, be_seen}, 32'h9);
    check(wdata_seen, 32'hFACE0001);
    retry_n = 2'h1;
    read_data = 32'hBEEF0002;
    host_op(1'b0, 1'b1, 24'h456788, 4'h3, 32'h0);
    check({24'h0, addr_count}, {24'h0, c0 + 8'h05});
    check(addr_seen, 32'h00456789);
    check(host_rdata, 32'hBEEF0002);
    retry_n = 2'h0;
  endtask

  // master and target aborts on writes and reads, flags and interrupt
  task automatic t_abort();
    logic [31:0] st;
    logic [7:0] c0;
    for (int k = 0; k < 4; k++)
    begin
      mode = k[1] ? 2'h2 : 2'h1;
      abort_irq_enable = k[0] ^ k[1];
      st = 32'h0;
      st[k[1] ? STAT_TARGET_ABORT : STAT_MASTER_ABORT] = 1'b1;
      c0 = addr_count;
      clr_master_abort = (k == 1); // held clear meets the set edge
      host_op(~k[0], 1'b0, 24'h020004, 4'hF, 32'h11112222);
      check(status, st);
      clr_master_abort = 1'b0;
      repeat (2) @(posedge clock);
      #1 check(status, st);
      check({31'h0, host_irq}, {31'h0, k[0] ^ k[1]});
      check({24'h0, addr_count}, {24'h0, c0 + 8'h01});
      if (k[0])
        check(host_rdata, ABORT_READ_DATA);
      {clr_master_abort, clr_target_abort} = 2'h3;
      @(posedge clock);
      #1 {clr_master_abort, clr_target_abort} = 2'h0;
      repeat (2) @(posedge clock);
      #1 check(status, STATUS_RESET);
    end
    mode = 2'h0;
  endtask

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      results();
    end
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    #1 srst = 1'b0;
    check(status, STATUS_RESET);
    t_direct();
    t_decode();
    t_retry();
    t_abort();
    results();
  end
endmodule

`default_nettype wire
